// ===== core/kwdt_pkg.sv
// Constants and types for the keyed watchdog timer
// How it works
// - Overflow with reset enable requests internal reset
// - Overflow with interrupt enable pulses interrupt line
// - Overflow with pin enable drives pin low 8 clocks
// - Timeout is 16-bit counter decremented per tick
// - Restart loads FFF plus preload-high nibble
// - Tick source divides clock by 32/128/1024/4096
// - Mode register changes only with matching key
// - Action mode key 0x234, key reads zero
// - Clock mode key 0x06E, key reads zero
// - Restart only when restart key is 0xC071
// - Disabled: no outputs; enabled: only enabled outputs
// - Overflow flag sticky until restart or reset
package kwdt_pkg;

	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_ACTION_MODE = 8'h00;
	localparam logic [7:0] OFS_CLOCK_MODE = 8'h04;
	localparam logic [7:0] OFS_RESTART = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	localparam int OMR_FIELD_MSB = 3;
	localparam int OMR_KEY_LSB = 4;
	localparam int OMR_KEY_MSB = 15;
	localparam logic [11:0] OMR_KEY = 12'h234;

	localparam int CMR_FIELD_MSB = 5;
	localparam int CMR_KEY_LSB = 7;
	localparam int CMR_KEY_MSB = 15;
	localparam logic [8:0] CMR_KEY = 9'h06E;

	localparam int RESTART_KEY_MSB = 15;
	localparam logic [15:0] RESTART_KEY = 16'hC071;

	localparam int CNT_W = 16;
	localparam logic [11:0] PRELOAD_LOW = 12'hFFF;

	localparam int PRESCALE_W = 12;
	localparam logic [11:0] DIV32_MASK = 12'h01F;
	localparam logic [11:0] DIV128_MASK = 12'h07F;
	localparam logic [11:0] DIV1024_MASK = 12'h3FF;
	localparam logic [11:0] DIV4096_MASK = 12'hFFF;

	localparam int PIN_PULSE_CYCLES = 8;

	localparam logic [3:0] OMR_RESET = 4'h0;
	localparam logic [5:0] CMR_RESET = 6'h00;

	typedef struct packed {
		logic pinEn;
		logic irq_on_overflow_en;
		logic reset_on_overflow_en;
		logic watchdog_enable_bit;
	} kwdt_omr_t;

	typedef struct packed {
		logic [3:0] preloadHigh;
		logic [1:0] tickSel;
	} kwdt_cmr_t;

endpackage

// ===== core/kwdt_prescaler.sv
// Tick generator dividing the system clock by a selectable power of two
`timescale 1ns/10ps
`default_nettype none
module kwdt_prescaler
	import kwdt_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [1:0] tickSel,
	input wire logic clr,
	output logic tick
);

	logic [PRESCALE_W-1:0] cnt_q;
	logic [PRESCALE_W-1:0] mask;

	always_comb begin
		case (tickSel)
			2'h0: mask = DIV32_MASK;
			2'h1: mask = DIV128_MASK;
			2'h2: mask = DIV1024_MASK;
			default: mask = DIV4096_MASK;
		endcase
	end

	// Free-running; restart clears it so the first period is full
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else begin
			cnt_q <= clr ? '0 : cnt_q + 1'b1;
			tick <= !clr && ((cnt_q & mask) == mask);
		end
	end

endmodule
`default_nettype wire

// ===== core/kwdt_pulse_stretch.sv
// Active-low pulse of fixed length on a one-cycle trigger
`timescale 1ns/10ps
`default_nettype none
module kwdt_pulse_stretch
	import kwdt_pkg::*;
#(
	parameter int LEN = PIN_PULSE_CYCLES
)(
	input wire logic clk,
	input wire logic nrst,
	input wire logic trig,
	output logic outN
);

	logic [$clog2(LEN+1)-1:0] cnt_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
			outN <= 1'b1;
		end else if (trig) begin
			cnt_q <= ($clog2(LEN+1))'(LEN - 1);
			outN <= 1'b0;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
			outN <= 1'b0;
		end else begin
			outN <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// ===== core/kwdt_top.sv
// Keyed watchdog timer with AHB-Lite register slave
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module kwdt_top
	import kwdt_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic internalResetReq,
	output logic overflowIrqPulse,
	output logic overflowOutN
);

	// Bus phase tracking

	logic [ADDR_W-1:0] addr_q;
	logic wrPend_q;
	logic rdPend_q;
	logic accept;

	// Only single word transfers are expected; size is not decoded
	assign accept = hsel && hready && htrans[1];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_q <= '0;
			wrPend_q <= 1'b0;
			rdPend_q <= 1'b0;
		end else begin
			if (accept) begin
				addr_q <= haddr[ADDR_W-1:0];
			end
			wrPend_q <= accept && hwrite;
			rdPend_q <= accept && !hwrite;
		end
	end

	// One wait state on reads so a read right after a write sees it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= !(accept && !hwrite);
			hresp <= 1'b0;
		end
	end

	// Write strobes in the data phase

	logic wrOmr;
	logic wrCmr;
	logic wrCr;
	logic omrKeyOk;
	logic cmrKeyOk;
	logic restart;

	assign wrOmr = wrPend_q && (addr_q == OFS_ACTION_MODE);
	assign wrCmr = wrPend_q && (addr_q == OFS_CLOCK_MODE);
	assign wrCr = wrPend_q && (addr_q == OFS_RESTART);
	assign omrKeyOk = hwdata[OMR_KEY_MSB:OMR_KEY_LSB] == OMR_KEY;
	assign cmrKeyOk = hwdata[CMR_KEY_MSB:CMR_KEY_LSB] == CMR_KEY;
	assign restart = wrCr &&
		(hwdata[RESTART_KEY_MSB:0] == RESTART_KEY);

	// Mode registers

	kwdt_omr_t omr_q;
	kwdt_cmr_t cmr_q;

	// Key and settings must arrive in one write; a bad key is dropped
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			omr_q <= kwdt_omr_t'(OMR_RESET);
		end else if (wrOmr && omrKeyOk) begin
			omr_q <= kwdt_omr_t'(hwdata[OMR_FIELD_MSB:0]);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cmr_q <= kwdt_cmr_t'(CMR_RESET);
		end else if (wrCmr && cmrKeyOk) begin
			cmr_q <= kwdt_cmr_t'(hwdata[CMR_FIELD_MSB:0]);
		end
	end

	// Tick source

	logic tick;

	kwdt_prescaler u_prescaler (
		.clk(clk),
		.nrst(nrst),
		.tickSel(cmr_q.tickSel),
		.clr(restart),
		.tick(tick)
	);

	// Down counter

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] preload;
	logic overflow;

	assign preload = {cmr_q.preloadHigh, PRELOAD_LOW};
	assign overflow = omr_q.watchdog_enable_bit && tick && (count_q == '0);

	// After an overflow the counter reloads, so an ignored watchdog
	// keeps firing once per period
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= '0;
		end else if (restart || overflow) begin
			count_q <= preload;
		end else if (omr_q.watchdog_enable_bit && tick) begin
			count_q <= count_q - 1'b1;
		end
	end

	// Overflow actions

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			internalResetReq <= 1'b0;
		end else begin
			internalResetReq <= overflow && omr_q.reset_on_overflow_en;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			overflowIrqPulse <= 1'b0;
		end else begin
			overflowIrqPulse <= overflow && omr_q.irq_on_overflow_en;
		end
	end

	kwdt_pulse_stretch #(
		.LEN(PIN_PULSE_CYCLES)
	) u_pin_pulse (
		.clk(clk),
		.nrst(nrst),
		.trig(overflow && omr_q.pinEn),
		.outN(overflowOutN)
	);

	// Status flag; an overflow in the restart cycle is kept

	logic overflowFlag_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			overflowFlag_q <= 1'b0;
		end else if (overflow) begin
			overflowFlag_q <= 1'b1;
		end else if (restart) begin
			overflowFlag_q <= 1'b0;
		end
	end

	// Read data

	logic [31:0] rdMux;

	// Key fields are never stored, so they read as zero
	always_comb begin
		case (addr_q)
			OFS_ACTION_MODE: rdMux = {28'h0000000, omr_q};
			OFS_CLOCK_MODE: rdMux = {26'h0, cmr_q};
			OFS_STATUS: rdMux = {31'h0, overflowFlag_q};
			default: rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hrdata <= 32'h00000000;
		end else if (rdPend_q) begin
			hrdata <= rdMux;
		end
	end

	// Checks

	// Tick spacing monitor; a divider change voids one period, so the
	// tick right after it is not timed
	logic [12:0] tickGap_q;
	logic [12:0] tickPeriod;
	logic [1:0] tickSelPrev_q;
	logic gapValid_q;

	always_comb begin
		case (cmr_q.tickSel)
			2'h0: tickPeriod = {1'b0, DIV32_MASK} + 13'h0001;
			2'h1: tickPeriod = {1'b0, DIV128_MASK} + 13'h0001;
			2'h2: tickPeriod = {1'b0, DIV1024_MASK} + 13'h0001;
			default: tickPeriod = {1'b0, DIV4096_MASK} + 13'h0001;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tickGap_q <= 13'h0000;
			tickSelPrev_q <= 2'h0;
			gapValid_q <= 1'b1;
		end else begin
			tickSelPrev_q <= cmr_q.tickSel;
			if (restart) begin
				tickGap_q <= 13'h0000;
			end else if (tick) begin
				tickGap_q <= 13'h0001;
			end else begin
				tickGap_q <= tickGap_q + 13'h0001;
			end
			if (cmr_q.tickSel != tickSelPrev_q) begin
				gapValid_q <= 1'b0;
			end else if (tick || restart) begin
				gapValid_q <= 1'b1;
			end
		end
	end

	resetReqCause_a: assert property (
		@(posedge clk) disable iff (!nrst)
		internalResetReq |-> $past(overflow && omr_q.reset_on_overflow_en))
		else $error("reset request without enabled overflow");

	resetReqPulse_a: assert property (
		@(posedge clk) disable iff (!nrst)
		internalResetReq |=> !internalResetReq)
		else $error("reset request longer than one cycle");

	irqPulseCause_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(overflow && omr_q.irq_on_overflow_en) |=> overflowIrqPulse ##1 !overflowIrqPulse)
		else $error("interrupt pulse missing or too long");

	pinLowEight_a: assert property (
		@(posedge clk) disable iff (!nrst)
		$fell(overflowOutN) |-> !overflowOutN[*8] ##1 overflowOutN)
		else $error("overflow pin low for wrong length");

	pinLowCause_a: assert property (
		@(posedge clk) disable iff (!nrst)
		$fell(overflowOutN) |-> $past(overflow && omr_q.pinEn))
		else $error("overflow pin fell without cause");

	countDecrement_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(omr_q.watchdog_enable_bit && tick && !restart && count_q != '0)
		|=> count_q == $past(count_q) - 16'h0001)
		else $error("counter did not decrement on tick");

	countHold_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(!omr_q.watchdog_enable_bit && !restart) |=> count_q == $past(count_q))
		else $error("counter moved while disabled");

	restartLoad_a: assert property (
		@(posedge clk) disable iff (!nrst)
		restart |=> count_q == {$past(cmr_q.preloadHigh), 12'hFFF})
		else $error("restart loaded wrong value");

	omrBadKey_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(wrOmr && hwdata[15:4] != 12'h234) |=> $stable(omr_q))
		else $error("action mode changed with bad key");

	cmrBadKey_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(wrCmr && hwdata[15:7] != 9'h06E) |=> $stable(cmr_q))
		else $error("clock mode changed with bad key");

	badRestart_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(wrCr && hwdata[15:0] != 16'hC071 && !omr_q.watchdog_enable_bit)
		|=> $stable(count_q) && $stable(overflowFlag_q))
		else $error("restart with wrong key had effect");

	disabledQuiet_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!omr_q.watchdog_enable_bit |=> !internalResetReq && !overflowIrqPulse
			&& !$fell(overflowOutN))
		else $error("output while watchdog disabled");

	flagSet_a: assert property (
		@(posedge clk) disable iff (!nrst)
		overflow |=> overflowFlag_q)
		else $error("overflow flag not set");

	flagClear_a: assert property (
		@(posedge clk) disable iff (!nrst)
		$fell(overflowFlag_q) |-> $past(restart))
		else $error("overflow flag cleared without restart");

	readWait_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(accept && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	writeNoWait_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(accept && hwrite) |=> hreadyout)
		else $error("write data phase stalled");

	tickSpacing_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(tick && gapValid_q && cmr_q.tickSel == tickSelPrev_q)
		|-> tickGap_q == tickPeriod)
		else $error("tick period does not match divider");

	overflowReload_a: assert property (
		@(posedge clk) disable iff (!nrst)
		overflow |=> count_q == $past(preload))
		else $error("counter not reloaded after overflow");

	flagHold_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(overflowFlag_q && !restart) |=> overflowFlag_q)
		else $error("overflow flag lost without restart");

	omrGoodKey_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(wrOmr && hwdata[15:4] == 12'h234)
		|=> omr_q == $past(hwdata[3:0]))
		else $error("action mode not written with good key");

	cmrGoodKey_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(wrCmr && hwdata[15:7] == 9'h06E)
		|=> cmr_q == $past(hwdata[5:0]))
		else $error("clock mode not written with good key");

	omrKeyRead_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(rdPend_q && addr_q == OFS_ACTION_MODE)
		|=> hrdata[31:4] == 28'h0000000)
		else $error("action mode key bits not read as zero");

	irqDisabled_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(overflow && !omr_q.irq_on_overflow_en) |=> !overflowIrqPulse)
		else $error("interrupt pulse while not enabled");

endmodule
`default_nettype wire

// ===== tb/kwdt_top_test.sv
// Self-checking bench for the keyed watchdog timer
`timescale 1ns/10ps
`default_nettype none
module kwdt_top_test
	import kwdt_pkg::*;
;
	logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, acc, en;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, hrdN, rd;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, rdyN;
	logic internalResetReq, overflowIrqPulse, overflowOutN;
	int nErrors = 0, nCompared = 0, tmo = 0;
	int cyc, nR, nI, nP, first;
	localparam logic [15:0] OMRV[6] = '{16'h234E, 16'h2343, 16'h2345,
		16'h2349, 16'h234F, 16'h235F};
	localparam logic [1:0] SEL[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
	localparam int DIVS[4] = '{32, 128, 1024, 4096};

	kwdt_top dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .internalResetReq(internalResetReq),
		.overflowIrqPulse(overflowIrqPulse), .overflowOutN(overflowOutN));

	always #25 clk = ~clk;

	// Outputs are registered, so the falling edge shows what the next
	// rising edge samples, without racing the design's updates
	always @(negedge clk) begin
		rdyN = hreadyout;
		hrdN = hrdata;
		if (!nrst) begin
			cyc = 0;
			nR = 0;
			nI = 0;
			nP = 0;
			first = 0;
		end else begin
			cyc++;
			nR += (internalResetReq === 1'b1);
			nI += (overflowIrqPulse === 1'b1);
			nP += (overflowOutN === 1'b0);
			if (first == 0 && (nR + nI + nP) > 0)
				first = cyc;
		end
	end

	always @(posedge clk) begin
		tmo <= tmo + 1;
		if (tmo == 20000) begin
			nErrors++;
			testDone();
		end
	end

	task check(input string nm, input logic [31:0] seen, exp);
		nCompared++;
		if (seen !== exp) begin
			nErrors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (rdyN !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (rdyN !== 1'b1);
		rd = hrdN;
	endtask

	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, '0);
		check(nm, rd, exp);
	endtask

	task doReset;
		nrst <= 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
	endtask

	task testDone;
		if (nErrors == 0 && nCompared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		doReset();
		rdchk("omr reset", OFS_ACTION_MODE, 0);
		rdchk("cmr reset", OFS_CLOCK_MODE, 0);
		rdchk("restart read", OFS_RESTART, 0);
		rdchk("status reset", OFS_STATUS, 0);
		rdchk("unmapped", 8'h40, 0);
		xfer(1'b1, OFS_CLOCK_MODE, 32'h363F);
		rdchk("cmr bad key", OFS_CLOCK_MODE, 0);
		@(negedge clk) check("hresp", hresp, 0);
		@(posedge clk);
		// Counter is zero after reset, so enabling overflows on the first
		// tick; this keeps each case short while timing the divider
		for (int i = 0; i < 6; i++) begin
			doReset();
			xfer(1'b1, OFS_CLOCK_MODE, 32'h3700 | SEL[i]);
			rdchk("cmr", OFS_CLOCK_MODE, SEL[i]);
			xfer(1'b1, OFS_ACTION_MODE, OMRV[i]);
			acc = OMRV[i][15:4] == 12'h234;
			en = acc & OMRV[i][0];
			rdchk("omr", OFS_ACTION_MODE, acc ? OMRV[i][3:0] : 0);
			while (cyc < DIVS[SEL[i]] + 40) @(posedge clk);
			check("reset pulses", nR, en & OMRV[i][1]);
			check("irq pulses", nI, en & OMRV[i][2]);
			check("pin low", nP, (en & OMRV[i][3]) * 8);
			check("tick time", !en || (first > DIVS[SEL[i]] - 4 &&
				first < DIVS[SEL[i]] + 16), 1);
			rdchk("status", OFS_STATUS, en);
		end
		doReset();
		xfer(1'b1, OFS_ACTION_MODE, 32'h2341);
		while (cyc < 80) @(posedge clk);
		xfer(1'b1, OFS_RESTART, 32'hC070);
		rdchk("status kept", OFS_STATUS, 1);
		xfer(1'b1, OFS_RESTART, 32'hC071);
		rdchk("status cleared", OFS_STATUS, 0);
		xfer(1'b1, OFS_ACTION_MODE, 32'h2340);
		xfer(1'b1, OFS_RESTART, 32'hC070);
		xfer(1'b1, OFS_CLOCK_MODE, 32'h373C);
		rdchk("cmr preload", OFS_CLOCK_MODE, 32'h3C);
		xfer(1'b1, OFS_RESTART, 32'hC071);
		xfer(1'b1, OFS_ACTION_MODE, 32'h2345);
		rdchk("omr irq", OFS_ACTION_MODE, 5);
		repeat (100) @(posedge clk);
		check("no early irq", nI, 0);
		testDone();
	end
endmodule
`default_nettype wire
